// ### hdl/ata_block_pkg.sv
/*
 * Shared constants, types and helpers for the pass-through block decoder.
 * Assumes a 16-byte command block presented as a packed byte array.
 */
package ata_block_pkg;

// =====================================================================
// Block layout
localparam int BLOCK_BYTES = 16;
localparam int BYTE_SIG = 0;
localparam int BYTE_SUB = 1;
localparam int BYTE_ACT = 2;
localparam int BYTE_MASK = 3;
localparam int BYTE_WDATA = 5;
localparam int BYTE_DEVICE = 11;
localparam logic [7:0] SUBCMD_ATA = 8'h24;

// =====================================================================
// Action-select bits
localparam int ACT_IDENT = 7;
localparam int ACT_UDMA = 6;
localparam int ACT_DEVSRC = 5;
localparam int ACT_HALT_DEV = 4;
localparam int ACT_HALT_PHASE = 3;
localparam int ACT_NOPOLL = 2;
localparam int ACT_SELAFTER = 1;
localparam int ACT_READBACK = 0;

// =====================================================================
// Task-file registers
localparam int TF_REGS = 8;
localparam int CFG_DEV_BIT = 5;
localparam int BLK_DEV_BIT = 4;
localparam int BUSY_BIT = 7;
localparam logic [2:0] IDX_ALT_STATUS = 3'h0;
localparam logic [2:0] IDX_DEVICE = 3'h6;
localparam logic [9:0] PORT_CONTROL = 10'h3F6;
localparam logic [9:0] PORT_BASE = 10'h1F0;
localparam logic [3:0] SCAN_FIRST = 4'h0;

// =====================================================================
// Types
typedef logic [BLOCK_BYTES-1:0][7:0] block_t;
typedef logic [TF_REGS-1:0][7:0] readback_t;

typedef struct packed {
    logic req;
    logic write;
    logic [2:0] idx;
    logic [9:0] port;
    logic [7:0] wdata;
} tf_cmd_t;

typedef struct packed {
    logic identify;
    logic udma;
    logic halt_dev;
    logic halt_phase;
    logic dev_bit;
    logic no_poll;
    logic sel_after;
    logic readback;
} mode_t;

// =====================================================================
// Helpers
function automatic mode_t decode_mode(block_t b, logic [7:0] cfg);
    mode_t m;
    m.identify = b[BYTE_ACT][ACT_IDENT];
    m.udma = b[BYTE_ACT][ACT_UDMA];
    m.dev_bit = b[BYTE_ACT][ACT_DEVSRC] ? b[BYTE_DEVICE][BLK_DEV_BIT]
                                        : cfg[CFG_DEV_BIT];
    m.halt_dev = ~b[BYTE_ACT][ACT_HALT_DEV];
    m.halt_phase = ~b[BYTE_ACT][ACT_HALT_PHASE];
    m.no_poll = b[BYTE_ACT][ACT_NOPOLL];
    m.sel_after = b[BYTE_ACT][ACT_SELAFTER];
    m.readback = b[BYTE_ACT][ACT_READBACK];
    return m;
endfunction : decode_mode

function automatic logic [9:0] port_of(logic [2:0] idx);
    return (idx == IDX_ALT_STATUS) ? PORT_CONTROL : (PORT_BASE | 10'(idx));
endfunction : port_of

function automatic logic [7:0] select_byte(block_t b, logic dev);
    logic [7:0] v;
    v = b[BYTE_DEVICE];
    v[BLK_DEV_BIT] = dev;
    return v;
endfunction : select_byte

endpackage : ata_block_pkg

// ### hdl/ata_command_block_decoder.sv
/*
 * Decoder and sequencer for vendor pass-through command blocks.
 * Assumes the task-file sequencer answers each access with tf_ack and
 * that the standard command path accepts std_valid at any time.
 */
`timescale 1ns/1ps
module ata_command_block_decoder (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cb_valid,
    input wire ata_block_pkg::block_t cb_block,
    input wire logic [7:0] cfg_signature,
    input wire logic [7:0] cfg_drive_byte,
    input wire logic tf_ack,
    input wire logic [7:0] tf_rdata,
    input wire logic dev_error,
    input wire logic phase_error,
    input wire logic xfer_done,
    output logic cb_ready,
    output logic std_valid,
    output ata_block_pkg::block_t std_block,
    output ata_block_pkg::tf_cmd_t tf_cmd,
    output ata_block_pkg::mode_t mode,
    output logic xfer_start,
    output logic xfer_halt,
    output logic done,
    output logic rb_valid,
    output ata_block_pkg::readback_t rb_data
);
    import ata_block_pkg::*;

    // =================================================================
    // State
    typedef enum logic [2:0] {
        ST_IDLE, ST_POLL, ST_SEL_PRE, ST_REGS, ST_SEL_POST, ST_XFER,
        ST_XWAIT, ST_REPLY
    } step_t;

    typedef struct packed {
        step_t step;
        logic cb_ready;
        logic std_valid;
        block_t std_block;
        block_t blk;
        mode_t mode;
        tf_cmd_t tf;
        logic [3:0] scan;
        logic xfer_start;
        logic xfer_halt;
        logic done;
        logic rb_valid;
        readback_t rb;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic match;
    mode_t in_mode;
    logic [7:0] mask;
    logic found;
    logic [2:0] found_idx;

    function automatic step_t after_poll(mode_t m);
        if (m.readback || m.sel_after) begin
            return ST_REGS;
        end
        return ST_SEL_PRE;
    endfunction : after_poll

    // =================================================================
    // Block recognition
    assign match = (cb_block[BYTE_SIG] == cfg_signature) &&
                   (cb_block[BYTE_SUB] == SUBCMD_ATA);
    assign in_mode = decode_mode(cb_block, cfg_drive_byte);
    // Selection is its own access in execute mode
    assign mask = cur.mode.readback ? cur.blk[BYTE_MASK]
                : (cur.blk[BYTE_MASK] & ~(8'h01 << IDX_DEVICE));

    mask_scan #(.WIDTH(TF_REGS)) u_scan (
        .mask(mask),
        .start(cur.scan),
        .found(found),
        .idx(found_idx)
    );

    // =================================================================
    // Next-state logic
    always_comb begin
        next_cur = cur;
        next_cur.std_valid = 1'b0;
        next_cur.xfer_start = 1'b0;
        next_cur.xfer_halt = 1'b0;
        next_cur.done = 1'b0;
        next_cur.rb_valid = 1'b0;
        case (cur.step)
            ST_IDLE: begin
                next_cur.cb_ready = 1'b1;
                if (cb_valid && cur.cb_ready) begin
                    if (match) begin
                        next_cur.cb_ready = 1'b0;
                        next_cur.blk = cb_block;
                        next_cur.mode = in_mode;
                        next_cur.scan = SCAN_FIRST;
                        next_cur.rb = '0;
                        next_cur.step = in_mode.no_poll ?
                            after_poll(in_mode) : ST_POLL;
                    end else begin
                        next_cur.std_valid = 1'b1;
                        next_cur.std_block = cb_block;
                    end
                end
            end
            ST_POLL: begin
                if (!cur.tf.req) begin
                    next_cur.tf = '{1'b1, 1'b0, IDX_ALT_STATUS,
                                    PORT_CONTROL, 8'h00};
                end else if (tf_ack) begin
                    next_cur.tf.req = 1'b0;
                    if (!tf_rdata[BUSY_BIT]) begin
                        next_cur.step = after_poll(cur.mode);
                    end
                end
            end
            ST_SEL_PRE, ST_SEL_POST: begin
                if (!cur.tf.req) begin
                    next_cur.tf = '{1'b1, 1'b1, IDX_DEVICE,
                                    port_of(IDX_DEVICE),
                                    select_byte(cur.blk,
                                                cur.mode.dev_bit)};
                end else if (tf_ack) begin
                    next_cur.tf.req = 1'b0;
                    next_cur.step = (cur.step == ST_SEL_PRE) ?
                        ST_REGS : ST_XFER;
                end
            end
            ST_REGS: begin
                if (!cur.tf.req) begin
                    if (found) begin
                        next_cur.tf = '{1'b1, ~cur.mode.readback, found_idx,
                                        port_of(found_idx),
                                        cur.blk[BYTE_WDATA + int'(found_idx)]};
                        next_cur.scan = {1'b0, found_idx} + 4'h1;
                    end else if (cur.mode.readback) begin
                        next_cur.step = ST_REPLY;
                    end else if (cur.mode.sel_after) begin
                        next_cur.step = ST_SEL_POST;
                    end else begin
                        next_cur.step = ST_XFER;
                    end
                end else if (tf_ack) begin
                    next_cur.tf.req = 1'b0;
                    if (cur.mode.readback) begin
                        next_cur.rb[cur.tf.idx] = tf_rdata;
                    end
                end
            end
            ST_XFER: begin
                next_cur.xfer_start = 1'b1;
                next_cur.step = ST_XWAIT;
            end
            ST_XWAIT: begin
                if ((dev_error && cur.mode.halt_dev) ||
                    (phase_error && cur.mode.halt_phase)) begin
                    next_cur.xfer_halt = 1'b1;
                    next_cur.done = 1'b1;
                    next_cur.step = ST_IDLE;
                end else if (xfer_done) begin
                    next_cur.done = 1'b1;
                    next_cur.step = ST_IDLE;
                end
            end
            ST_REPLY: begin
                next_cur.rb_valid = 1'b1;
                next_cur.done = 1'b1;
                next_cur.step = ST_IDLE;
            end
            default: begin
                next_cur = '0;
            end
        endcase
    end

    // =================================================================
    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    assign cb_ready = cur.cb_ready;
    assign std_valid = cur.std_valid;
    assign std_block = cur.std_block;
    assign tf_cmd = cur.tf;
    assign mode = cur.mode;
    assign xfer_start = cur.xfer_start;
    assign xfer_halt = cur.xfer_halt;
    assign done = cur.done;
    assign rb_valid = cur.rb_valid;
    assign rb_data = cur.rb;

    // =================================================================
    // Checks
    logic [7:0] issued;
    logic take;
    logic issue_reg;
    logic [63:0] sel_bytes;

    // Mask widened to one byte lane per task-file register
    always_comb begin
        for (int i = 0; i < TF_REGS; i++) begin
            sel_bytes[8*i +: 8] = {8{cur.blk[BYTE_MASK][i]}};
        end
    end

    assign take = ce && cb_valid && cur.cb_ready && (cur.step == ST_IDLE);
    assign issue_reg = ce && (cur.step == ST_REGS) && !cur.tf.req && found;

    always_ff @(posedge mclk) begin
        if (rst) begin
            issued <= 8'h00;
        end else if (take) begin
            issued <= 8'h00;
        end else if (issue_reg) begin
            issued <= issued | (8'h01 << found_idx);
        end
    end

    sequence s_take_match;
        take && match;
    endsequence

    sequence s_take_foreign;
        take && !match;
    endsequence

    a_foreign_passed: assert property (@(posedge mclk) disable iff (rst)
        s_take_foreign |=> std_valid && std_block == $past(cb_block))
        else $error("foreign block not passed on");

    a_match_kept: assert property (@(posedge mclk) disable iff (rst)
        s_take_match |=> !std_valid && cur.step != ST_IDLE)
        else $error("matching block leaked or ignored");

    a_poll_choice: assert property (@(posedge mclk) disable iff (rst)
        s_take_match |=> ((cur.step == ST_POLL) ==
                          !$past(cb_block[BYTE_ACT][ACT_NOPOLL])))
        else $error("busy poll choice wrong");

    a_flags_decoded: assert property (@(posedge mclk) disable iff (rst)
        s_take_match |=> mode.udma == $past(cb_block[BYTE_ACT][ACT_UDMA])
            && mode.identify == $past(cb_block[BYTE_ACT][ACT_IDENT])
            && mode.halt_dev == !$past(cb_block[BYTE_ACT][ACT_HALT_DEV])
            && mode.halt_phase == !$past(cb_block[BYTE_ACT][ACT_HALT_PHASE]))
        else $error("action flags decoded wrong");

    a_select_source: assert property (@(posedge mclk) disable iff (rst)
        tf_cmd.req && tf_cmd.write && tf_cmd.idx == IDX_DEVICE
        |-> tf_cmd.wdata[BLK_DEV_BIT] == mode.dev_bit)
        else $error("drive select bit from wrong source");

    a_select_order: assert property (@(posedge mclk) disable iff (rst)
        $rose(cur.step == ST_SEL_POST)
        |-> mode.sel_after && !mode.readback)
        else $error("selection placed in wrong order");

    a_regs_ascend: assert property (@(posedge mclk) disable iff (rst)
        issue_reg |-> (issued >> found_idx) == 8'h00
                      && mask[found_idx])
        else $error("register access out of order");

    a_readback_zero: assert property (@(posedge mclk) disable iff (rst)
        rb_valid |-> (rb_data & ~sel_bytes) == 64'h0 && done)
        else $error("read-back reply malformed");

    a_unmasked_zero: assert property (@(posedge mclk) disable iff (rst)
        rb_valid |-> (rb_data[7] == 8'h00 || cur.blk[BYTE_MASK][7])
                 && (rb_data[0] == 8'h00 || cur.blk[BYTE_MASK][0]))
        else $error("unmasked register returned data");

    a_halt_stops: assert property (@(posedge mclk) disable iff (rst)
        ce && cur.step == ST_XWAIT && dev_error && mode.halt_dev
        |=> xfer_halt && done ##1 cur.step == ST_IDLE)
        else $error("device error did not halt");
endmodule : ata_command_block_decoder

// ### hdl/mask_scan.sv
/*
 * Finds the lowest set mask bit at or above a start position.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module mask_scan #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] mask,
    input wire logic [$clog2(WIDTH):0] start,
    output logic found,
    output logic [$clog2(WIDTH)-1:0] idx
);
    // =================================================================
    // Downward loop so the lowest qualifying bit wins
    always_comb begin
        found = 1'b0;
        idx = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (mask[i] && (i >= int'(start))) begin
                found = 1'b1;
                idx = i[$clog2(WIDTH)-1:0];
            end
        end
    end
endmodule : mask_scan

// ### verif/ata_command_block_decoder_tb.sv
/*
 * Self-checking bench for the pass-through block decoder.
 * Assumes tf_partner answers the task-file port.
 */
`timescale 1ns/1ps
module ata_command_block_decoder_tb;
    import ata_block_pkg::*;
    typedef struct packed {
        logic [1:0] kind;
        logic [127:0] val;
    } note_t;
    logic mclk, rst, ce, cb_valid, tf_ack, dev_error, phase_error;
    logic xfer_done, cb_ready, std_valid, xfer_start, xfer_halt, done;
    logic rb_valid, slow, busy_load, ok;
    logic [7:0] cfg_signature, cfg_drive_byte, tf_rdata, rd_base;
    logic [3:0] busy_reads;
    block_t cb_block, std_block, fb;
    tf_cmd_t tf_cmd;
    mode_t mode;
    readback_t rb_data;
    note_t notes[$];
    note_t nt;
    int mismatches, checks_done, cycles;

    ata_command_block_decoder u_ata_command_block_decoder (
        .mclk(mclk), .rst(rst), .ce(ce), .cb_valid(cb_valid),
        .cb_block(cb_block), .cfg_signature(cfg_signature),
        .cfg_drive_byte(cfg_drive_byte), .tf_ack(tf_ack),
        .tf_rdata(tf_rdata), .dev_error(dev_error),
        .phase_error(phase_error), .xfer_done(xfer_done),
        .cb_ready(cb_ready), .std_valid(std_valid), .std_block(std_block),
        .tf_cmd(tf_cmd), .mode(mode), .xfer_start(xfer_start),
        .xfer_halt(xfer_halt), .done(done), .rb_valid(rb_valid),
        .rb_data(rb_data));
    tf_partner u_tf_partner (
        .mclk(mclk), .rst(rst), .tf_cmd(tf_cmd), .slow(slow),
        .busy_load(busy_load), .busy_reads(busy_reads), .rd_base(rd_base),
        .tf_ack(tf_ack), .tf_rdata(tf_rdata));

    // ==================================================================
    // Clock, timeout and reporting
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic c, input string msg);
        checks_done++;
        if (c !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            end_sim();
        end
    end
    // ==================================================================
    // Output watcher: each result takes the oldest note
    always @(negedge mclk) begin
        if (!rst && ((tf_cmd.req && tf_ack) || std_valid || rb_valid
                     || xfer_start) === 1'b1) begin
            ok = 1'b0;
            if (notes.size() != 0) begin
                nt = notes.pop_front();
                case (nt.kind)
                    2'h0: ok = (tf_cmd.req && tf_ack) === 1'b1
                        && {tf_cmd.port, tf_cmd.idx, tf_cmd.write}
                           === nt.val[13:0]
                        && (!nt.val[0] || tf_cmd.wdata === nt.val[21:14]);
                    2'h1: ok = rb_valid === 1'b1 && rb_data === nt.val[63:0]
                        && mode === nt.val[71:64];
                    2'h2: ok = std_valid === 1'b1 && std_block === nt.val;
                    default: ok = xfer_start === 1'b1
                        && mode === nt.val[7:0];
                endcase
            end
            chk(ok, "output differs from expected");
        end
    end
    // ==================================================================
    // Stimulus helpers
    task automatic wait_hi(ref logic s);
        int k;
        k = 0;
        while (s !== 1'b1 && k < 500) begin
            @(posedge mclk);
            #1;
            k++;
        end
        chk(k < 500, "wait ran out");
    endtask : wait_hi
    task automatic offer(input block_t b);
        cb_block = b;
        if (cb_valid !== 1'b1) cb_valid = 1'b1;
        wait_hi(cb_ready);
        @(posedge mclk);
        #1;
    endtask : offer
    function automatic logic [7:0] rdv(input logic [2:0] i);
        return (i == 3'h0) ? {1'b0, rd_base[6:0]} : rd_base + 8'({i, 4'h0});
    endfunction : rdv
    function automatic void acc(input logic w, input logic [2:0] i,
                                input logic [7:0] d);
        logic [9:0] p;
        p = (i == 3'h0) ? 10'h3F6 : 10'h1F0 + 10'(i);
        notes.push_back({2'h0, 106'h0, d, p, i, w});
    endfunction : acc
    task automatic run(input logic [7:0] act, input logic [7:0] msk,
                       input logic [3:0] nb, input logic sl, input int fin);
        block_t b;
        logic [7:0] sel, m;
        logic [63:0] rb;
        logic h;
        for (int i = 0; i < BLOCK_BYTES; i++) b[i] = 8'($urandom);
        b[0] = cfg_signature;
        b[1] = 8'h24;
        b[2] = act;
        b[3] = msk;
        sel = b[11];
        if (!act[5]) sel[4] = cfg_drive_byte[5];
        m = {act[7], act[6], ~act[4], ~act[3], sel[4], act[2:0]};
        slow = sl;
        busy_reads = nb;
        busy_load = 1'b1;
        @(posedge mclk);
        #1;
        busy_load = 1'b0;
        if (!act[2]) for (int i = 0; i <= nb; i++) acc(0, 3'h0, 8'h00);
        if (act[0]) begin
            rb = '0;
            for (int i = 0; i < 8; i++) begin
                if (msk[i]) acc(0, 3'(i), 8'h00);
                if (msk[i]) rb[8*i +: 8] = rdv(3'(i));
            end
            if (act[2] && nb != 4'h0) rb[7] = msk[0];
            notes.push_back({2'h1, 56'h0, m, rb});
        end else begin
            if (!act[1]) acc(1, 3'h6, sel);
            for (int i = 0; i < 8; i++)
                if (msk[i] && i != 6) acc(1, 3'(i), b[5+i]);
            if (act[1]) acc(1, 3'h6, sel);
            notes.push_back({2'h3, 120'h0, m});
        end
        offer(b);
        cb_valid = 1'b0;
        if (act[0]) wait_hi(done);
        else begin
            wait_hi(xfer_start);
            h = (fin == 1) ? ~act[4] : (fin == 2) ? ~act[3] : 1'b0;
            dev_error = (fin == 1);
            phase_error = (fin == 2);
            xfer_done = (fin == 0);
            @(posedge mclk);
            #1;
            dev_error = 1'b0;
            phase_error = 1'b0;
            xfer_done = 1'b0;
            chk(done === (fin == 0 || h) && xfer_halt === h, "halt");
            if (fin != 0 && !h) begin
                xfer_done = 1'b1;
                @(posedge mclk);
                #1;
                xfer_done = 1'b0;
                chk(done === 1'b1 && xfer_halt === 1'b0, "finish");
            end
        end
        wait_hi(cb_ready);
    endtask : run
    // ==================================================================
    // Main sequence
    initial begin
        void'($urandom(11342));
        {ce, cb_valid, dev_error, phase_error, xfer_done} = 5'h00;
        {slow, busy_load, busy_reads, mismatches, checks_done} = '0;
        {cycles, cb_block, fb} = '0;
        rst = 1'b1;
        cfg_signature = 8'($urandom);
        cfg_drive_byte = 8'($urandom);
        rd_base = 8'($urandom);
        repeat (4) @(posedge mclk);
        #1;
        rst = 1'b0;
        ce = 1'b1;
        chk(cb_ready === 1'b0 && done === 1'b0, "reset outputs");
        wait_hi(cb_ready);
        for (int k = 0; k < 4; k++) begin
            fb = {$urandom, $urandom, $urandom, $urandom};
            fb[0] = (k == 1) ? cfg_signature : ~cfg_signature;
            fb[1] = (k == 1) ? 8'h25 : (k == 3) ? fb[1] : 8'h24;
            if (k == 0) begin
                cb_block = fb;
                cb_valid = 1'b1;
                ce = 1'b0;
                repeat (3) begin
                    @(posedge mclk);
                    #1;
                    chk(std_valid === 1'b0 && cb_ready === 1'b1,
                        "frozen block passed");
                end
                ce = 1'b1;
            end
            notes.push_back({2'h2, fb});
            offer(fb);
        end
        cb_valid = 1'b0;
        // Read-back blocks keep bits 4:3 clear, eight-byte length
        run(8'h05, 8'h81, 4'h0, 1'b0, 0);
        run(8'h01, 8'hFF, 4'h2, 1'b1, 0);
        run(8'h23, 8'h00, 4'h0, 1'b0, 0);
        run(8'({$urandom, 3'h1} & 8'hE7), 8'($urandom), 4'h1, 1'b0, 0);
        for (int k = 0; k < 10; k++) begin
            logic [2:0] kk;
            kk = 3'(k);
            run({3'($urandom), kk[1:0], kk[0] ^ kk[2], kk[1] ^ kk[2], 1'b0},
                8'($urandom), 4'(k % 3), kk[0],
                (k >= 8) ? 0 : (kk[2] ? 2 : 1));
        end
        repeat (3) @(posedge mclk);
        chk(notes.size() == 0, "results missing");
        end_sim();
    end
endmodule : ata_command_block_decoder_tb

// ### verif/tf_partner.sv
/*
 * Task-file sequencer model: answers each access after one or four cycles.
 * Assumes tf_cmd holds steady while req is high.
 */
`timescale 1ns/1ps
module tf_partner (
    input wire logic mclk,
    input wire logic rst,
    input wire ata_block_pkg::tf_cmd_t tf_cmd,
    input wire logic slow,
    input wire logic busy_load,
    input wire logic [3:0] busy_reads,
    input wire logic [7:0] rd_base,
    output logic tf_ack,
    output logic [7:0] tf_rdata
);
    import ata_block_pkg::*;
    logic [1:0] cnt;
    logic [3:0] busy;
    logic [7:0] rd_value;
    // ==================================================================
    // Read data: alternate status shows busy while the count lasts
    always_comb begin
        rd_value = rd_base + 8'({tf_cmd.idx, 4'h0});
        if (tf_cmd.idx == IDX_ALT_STATUS) begin
            rd_value = {busy != 4'h0, rd_base[6:0]};
        end
    end
    // ==================================================================
    // Answer, with data lines toggling outside the ack cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt <= 2'h0;
            busy <= 4'h0;
            tf_ack <= 1'b0;
            tf_rdata <= 8'h00;
        end else begin
            tf_ack <= 1'b0;
            tf_rdata <= ~tf_rdata;
            if (busy_load) begin
                busy <= busy_reads;
            end
            if (tf_cmd.req && !tf_ack) begin
                if (cnt >= (slow ? 2'h3 : 2'h0)) begin
                    cnt <= 2'h0;
                    tf_ack <= 1'b1;
                    tf_rdata <= rd_value;
                    if (tf_cmd.idx == IDX_ALT_STATUS && busy != 4'h0) begin
                        busy <= busy - 4'h1;
                    end
                end else begin
                    cnt <= cnt + 2'h1;
                end
            end
        end
    end
endmodule : tf_partner
